// *** core/pin_mapper_pkg.sv ***
package pin_mapper_pkg;

  localparam int PIN_COUNT   = 36;
  localparam int NARROW_LOW  = 12;
  localparam int COMP_A_W    = 12;
  localparam int COMP_B_W    = 10;
  localparam int SYNC_COUNT  = 3;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;

  // Control register field positions.
  localparam int CTRL_NARROW_BIT  = 0;
  localparam int CTRL_MAP_LSB     = 1;
  localparam int CTRL_FMT_A_LSB   = 3;
  localparam int CTRL_FMT_B_LSB   = 5;
  localparam int CTRL_EIGHT_BIT   = 7;
  localparam int CTRL_TRIPLE_BIT  = 8;
  localparam int CTRL_MAIN_BIT    = 9;
  localparam int CTRL_CAPTURE_BIT = 10;
  localparam int CFG_W            = 10;

  // Status register field positions.
  localparam int STAT_PENDING_BIT  = 16;
  localparam int STAT_CONFLICT_BIT = 17;
  localparam int STAT_BAD_MAP_BIT  = 18;

  // Control reset value: narrow input, map 00, both formats 10, main select 1.
  localparam logic [10:0] CTRL_RESET = 11'h251;

  localparam logic [1:0] MAP_00 = 2'b00;
  localparam logic [1:0] MAP_01 = 2'b01;
  localparam logic [1:0] MAP_10 = 2'b10;
  localparam logic [1:0] MAP_11 = 2'b11;

  localparam logic [1:0] FMT_00 = 2'b00;
  localparam logic [1:0] FMT_01 = 2'b01;
  localparam logic [1:0] FMT_10 = 2'b10;
  localparam logic [1:0] FMT_11 = 2'b11;

  typedef enum logic [1:0] {
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage

// *** core/video_input_pin_mapper.sv ***
// Contract
// - Thirty-six input pins 0..35 with selectable narrow 24-pin or full 36-pin width.
// - Narrow width uses only pins 35..12 with the three narrow pin maps.
// - Map select picks the map; port A format, 8-bit and 4:4:4 bits pick assignment inside it.
// - Narrow map 00 dual multiplexed: A from 35..26, B from 25..16; 8-bit higher.
// - Narrow map 00 single YC: 20-bit luma 35..26 chroma 25..16; 16-bit higher.
// - Narrow map 00 4:4:4: blue 12..19, green 20..27, red 28..35, LSB first.
// - Narrow map 10 reverses order; 10-bit low bits on pins 28,29,32,33.
// - Narrow map 11: A low bits 14-15 high 20-27; B low 18-19 high 28-35.
// - Full map 00 dual multiplexed: A from pins 26..35, B from pins 6..15.
// - Full map 00 dual YC: A luma 26..35, chroma 16..25; B luma 8..15, chroma 0..7.
// - Full map 00 4:4:4 30-bit: red 6..15, blue 16..25, green 26..35.
// - Full map 01 dual 8-bit forms; port B syncs from pins 0, 1, 2.
// - Full map 10 36-bit: red, green, blue groups of twelve, MSB first.
// - Full map 11 36-bit: blue, green, red groups of twelve, LSB first.
module video_input_pin_mapper
  import pin_mapper_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic [3:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic [PIN_COUNT-1:0]  video_pins_i,
  input  wire logic                  port_a_line_active_i,
  input  wire logic                  port_a_frame_active_i,
  input  wire logic                  port_a_field_flag_i,
  output logic      [COMP_A_W-1:0]   port_a_luma_o,
  output logic      [COMP_A_W-1:0]   port_a_blue_o,
  output logic      [COMP_A_W-1:0]   port_a_red_o,
  output logic      [COMP_B_W-1:0]   port_b_luma_o,
  output logic      [COMP_B_W-1:0]   port_b_chroma_o,
  output logic                       port_a_line_active_o,
  output logic                       port_a_frame_active_o,
  output logic                       port_a_field_flag_o,
  output logic                       port_b_line_active_o,
  output logic                       port_b_frame_active_o,
  output logic                       port_b_field_flag_o,
  output logic                       capture_active_o,
  output logic                       main_path_select_o
);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  function automatic logic [11:0] rev12(input logic [11:0] v);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 12; i++) begin
      r[i] = v[11-i];
    end
    return r;
  endfunction

  logic                 rst_meta_reg;
  logic                 rst_n_reg;
  logic [PIN_COUNT+2:0] pin_meta_reg;
  logic [PIN_COUNT+2:0] pin_sync_reg;
  logic [PIN_COUNT-1:0] pin_s;

  // Reset release and pin sampling through two flip-flops each.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {port_a_field_flag_i, port_a_frame_active_i, port_a_line_active_i, video_pins_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign pin_s = pin_sync_reg[PIN_COUNT-1:0];

  // Bus slave and configuration.
  bus_state_e       bus_reg;
  bus_state_e       bus_next;
  logic [10:0]      ctrl_reg;
  logic [10:0]      ctrl_next;
  logic [CFG_W-1:0] active_reg;
  logic [CFG_W-1:0] active_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             bad_map;
  logic             conflict;

  // Every 4:4:4 format and every format, narrow or full, that is not a dual one counts as port A only.
  assign conflict = !ctrl_reg[CTRL_MAIN_BIT] && (active_reg[CTRL_TRIPLE_BIT] ||
                    !(active_reg[CTRL_FMT_A_LSB +: 2] == FMT_10 ||
                      (!active_reg[CTRL_NARROW_BIT] && active_reg[CTRL_FMT_A_LSB +: 2] == FMT_11)));

  always_comb begin
    bus_next    = bus_reg;
    ctrl_next   = ctrl_reg;
    rdata_next  = rdata_reg;
    active_next = active_reg;
    case (bus_reg)
      BUS_WAIT: begin
        if (avs_read_i || avs_write_i) begin
          bus_next   = BUS_ACK;
          rdata_next = '0;
          if (avs_read_i && avs_address_i == CTRL_ADDR) begin
            rdata_next[10:0] = ctrl_reg;
          end else if (avs_read_i && avs_address_i == STATUS_ADDR) begin
            rdata_next[CFG_W-1:0]        = active_reg;
            rdata_next[STAT_PENDING_BIT]  = active_reg != ctrl_reg[CFG_W-1:0];
            rdata_next[STAT_CONFLICT_BIT] = conflict;
            rdata_next[STAT_BAD_MAP_BIT]  = bad_map;
          end
        end
      end
      BUS_ACK: begin
        bus_next = BUS_WAIT;
        if (avs_write_i && avs_address_i == CTRL_ADDR) begin
          if (avs_byteenable_i[0]) begin
            ctrl_next[7:0] = avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            ctrl_next[10:8] = avs_writedata_i[10:8];
          end
        end
      end
      default: bus_next = BUS_WAIT;
    endcase
    // New map, width and formats reach the datapath only while capture is idle.
    if (!ctrl_reg[CTRL_CAPTURE_BIT]) begin
      active_next = ctrl_reg[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bus_reg    <= BUS_WAIT;
      ctrl_reg   <= CTRL_RESET;
      active_reg <= CTRL_RESET[CFG_W-1:0];
      rdata_reg  <= '0;
    end else begin
      bus_reg    <= bus_next;
      ctrl_reg   <= ctrl_next;
      active_reg <= active_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  // Bit 0 of the one-hot state marks the idle state, so waitrequest comes straight from a flip-flop.
  assign avs_waitrequest_o = bus_reg[0];

  // Pin map datapath.
  logic                narrow;
  logic [1:0]          map_sel;
  logic [1:0]          fmt_a;
  logic                eight;
  logic                triple;
  logic                dual;
  logic [COMP_A_W-1:0] a_y_next, a_c_next, a_r_next;
  logic [COMP_A_W-1:0] a_y_reg, a_c_reg, a_r_reg;
  logic [COMP_B_W-1:0] b_y_next, b_c_next;
  logic [COMP_B_W-1:0] b_y_reg, b_c_reg;
  logic [9:0]          word_a, word_b;
  logic [2:0]          b_sync_next, b_sync_reg;
  logic [2:0]          a_sync_reg;
  logic                cap_reg, main_reg;

  assign narrow  = active_reg[CTRL_NARROW_BIT];
  assign map_sel = active_reg[CTRL_MAP_LSB +: 2];
  assign fmt_a   = active_reg[CTRL_FMT_A_LSB +: 2];
  assign eight   = active_reg[CTRL_EIGHT_BIT];
  assign triple  = active_reg[CTRL_TRIPLE_BIT];
  assign dual    = (fmt_a == FMT_10) || (!narrow && fmt_a == FMT_11);
  assign bad_map = narrow && map_sel == MAP_01;

  // Unassigned bits stay zero, so no unused pin reaches a component.
  always_comb begin
    a_y_next = '0;
    a_c_next = '0;
    a_r_next = '0;
    b_y_next = '0;
    b_c_next = '0;
    b_sync_next = '0;
    word_a = '0;
    word_b = '0;
    if (narrow) begin
      case (map_sel)
        MAP_00: begin
          if (triple) begin
            a_c_next[7:0] = pin_s[19:12];
            a_y_next[7:0] = pin_s[27:20];
            a_r_next[7:0] = pin_s[35:28];
          end else begin
            if ((dual && eight) || (!dual && fmt_a == FMT_01)) begin
              word_a[7:0] = pin_s[35:28];
              word_b[7:0] = pin_s[25:18];
            end else begin
              word_a = pin_s[35:26];
              word_b = pin_s[25:16];
            end
          end
        end
        MAP_10: begin
          if (triple) begin
            a_r_next[7:0] = rev8(pin_s[19:12]);
            a_y_next[7:0] = rev8(pin_s[27:20]);
            a_c_next[7:0] = rev8(pin_s[35:28]);
          end else if (eight) begin
            word_a[7:0] = rev8(pin_s[27:20]);
            word_b[7:0] = rev8(pin_s[19:12]);
          end else begin
            word_a = {rev8(pin_s[27:20]), pin_s[32], pin_s[33]};
            word_b = {rev8(pin_s[19:12]), pin_s[28], pin_s[29]};
          end
        end
        MAP_11: begin
          if (triple) begin
            a_c_next[7:0] = pin_s[19:12];
            a_y_next[7:0] = pin_s[27:20];
            a_r_next[7:0] = pin_s[35:28];
          end else if (eight) begin
            word_a[7:0] = pin_s[27:20];
            word_b[7:0] = pin_s[35:28];
          end else begin
            word_a = {pin_s[27:20], pin_s[15:14]};
            word_b = {pin_s[35:28], pin_s[19:18]};
          end
        end
        default: begin
          word_a = '0;
        end
      endcase
      a_y_next[9:0] = a_y_next[9:0] | word_a;
      if (dual) begin
        b_y_next = word_b;
      end else begin
        a_c_next[9:0] = a_c_next[9:0] | word_b;
      end
    end else begin
      case (map_sel)
        MAP_00: begin
          if (triple) begin
            a_r_next[9:0] = pin_s[15:6];
            a_c_next[9:0] = pin_s[25:16];
            a_y_next[9:0] = pin_s[35:26];
          end else if (fmt_a == FMT_10) begin
            a_y_next[9:0] = pin_s[35:26];
            b_y_next      = pin_s[15:6];
          end else begin
            a_y_next[9:0] = pin_s[35:26];
            a_c_next[9:0] = pin_s[25:16];
            b_y_next[7:0] = pin_s[15:8];
            b_c_next[7:0] = pin_s[7:0];
          end
        end
        MAP_01: begin
          b_sync_next = pin_s[2:0];
          a_y_next[7:0] = pin_s[35:28];
          b_y_next[7:0] = pin_s[19:12];
          if (fmt_a != FMT_10) begin
            a_c_next[7:0] = pin_s[27:20];
            b_c_next[7:0] = pin_s[11:4];
          end
        end
        MAP_10: begin
          a_r_next = rev12(pin_s[11:0]);
          a_y_next = rev12(pin_s[23:12]);
          a_c_next = rev12(pin_s[35:24]);
        end
        default: begin
          a_c_next = pin_s[11:0];
          a_y_next = pin_s[23:12];
          a_r_next = pin_s[35:24];
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      a_y_reg    <= '0;
      a_c_reg    <= '0;
      a_r_reg    <= '0;
      b_y_reg    <= '0;
      b_c_reg    <= '0;
      b_sync_reg <= '0;
      a_sync_reg <= '0;
      cap_reg    <= 1'b0;
      main_reg   <= 1'b1;
    end else begin
      a_y_reg    <= a_y_next;
      a_c_reg    <= a_c_next;
      a_r_reg    <= a_r_next;
      b_y_reg    <= b_y_next;
      b_c_reg    <= b_c_next;
      b_sync_reg <= b_sync_next;
      a_sync_reg <= pin_sync_reg[PIN_COUNT+2:PIN_COUNT];
      cap_reg    <= ctrl_reg[CTRL_CAPTURE_BIT];
      main_reg   <= ctrl_reg[CTRL_MAIN_BIT];
    end
  end

  assign port_a_luma_o         = a_y_reg;
  assign port_a_blue_o         = a_c_reg;
  assign port_a_red_o          = a_r_reg;
  assign port_b_luma_o         = b_y_reg;
  assign port_b_chroma_o       = b_c_reg;
  assign port_b_field_flag_o   = b_sync_reg[0];
  assign port_b_line_active_o  = b_sync_reg[1];
  assign port_b_frame_active_o = b_sync_reg[2];
  assign port_a_line_active_o  = a_sync_reg[0];
  assign port_a_frame_active_o = a_sync_reg[1];
  assign port_a_field_flag_o   = a_sync_reg[2];
  assign capture_active_o      = cap_reg;
  assign main_path_select_o    = main_reg;

  // Helper copy of the sampled pins for the checks below.
  logic [PIN_COUNT-1:0] pin_prev;
  always_ff @(posedge clk_i) begin
    pin_prev <= pin_s;
  end

  a_narrow_dual_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    narrow && map_sel == MAP_00 && !triple && fmt_a == FMT_10 && !eight
    |=> port_a_luma_o[9:0] == pin_prev[35:26] && port_b_luma_o == pin_prev[25:16])
    else $error("narrow map 00 dual port routing wrong");
  a_narrow_yc_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    narrow && map_sel == MAP_00 && !triple && fmt_a == FMT_01
    |=> port_a_luma_o == {4'h0, pin_prev[35:28]} && port_a_blue_o == {4'h0, pin_prev[25:18]})
    else $error("narrow map 00 16-bit YC routing wrong");
  a_narrow_rgb_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    narrow && map_sel == MAP_00 && triple
    |=> port_a_blue_o[7:0] == pin_prev[19:12] && port_a_red_o[7:0] == pin_prev[35:28])
    else $error("narrow map 00 4:4:4 routing wrong");
  a_reversed_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    narrow && map_sel == MAP_10 && !triple && !eight
    |=> port_a_luma_o[9] == pin_prev[20] && port_a_luma_o[0] == pin_prev[33])
    else $error("narrow map 10 bit order wrong");
  a_split_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    narrow && map_sel == MAP_11 && !triple && !eight
    |=> port_a_luma_o[1:0] == pin_prev[15:14] && port_a_luma_o[9:2] == pin_prev[27:20])
    else $error("narrow map 11 split routing wrong");
  a_full_dual_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_00 && !triple && fmt_a == FMT_10
    |=> port_b_luma_o == pin_prev[15:6] && port_b_chroma_o == 10'h000)
    else $error("full map 00 dual multiplexed routing wrong");
  a_full_yc_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_00 && !triple && fmt_a == FMT_11
    |=> port_b_chroma_o == {2'b00, pin_prev[7:0]} && port_a_blue_o[9:0] == pin_prev[25:16])
    else $error("full map 00 dual YC routing wrong");
  a_full_rgb_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_00 && triple
    |=> port_a_red_o[9:0] == pin_prev[15:6] && port_a_luma_o[9:0] == pin_prev[35:26])
    else $error("full map 00 30-bit routing wrong");
  a_port_b_sync: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_01
    |=> port_b_field_flag_o == pin_prev[0] && port_b_frame_active_o == pin_prev[2])
    else $error("port B sync pins wrong");
  a_msb_first_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_10 |=> port_a_red_o[11] == pin_prev[0] && port_a_blue_o[0] == pin_prev[35])
    else $error("full map 10 order wrong");
  a_lsb_first_map: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    !narrow && map_sel == MAP_11 |=> port_a_red_o == pin_prev[35:24] && port_a_blue_o == pin_prev[11:0])
    else $error("full map 11 order wrong");
  a_config_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    ctrl_reg[CTRL_CAPTURE_BIT] |=> $stable(active_reg))
    else $error("active configuration changed during capture");

endmodule

// *** verif/video_source_model.sv ***
module video_source_model (
  input  wire logic        clk_i,
  input  wire logic [35:0] word_i,
  input  wire logic [2:0]  sync_i,
  output logic      [35:0] pins_o,
  output logic             line_o,
  output logic             frame_o,
  output logic             field_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // The source launches each word just after a rising edge, like a registered transmitter.
  always @(posedge clk_i) begin
    pins_o <= word_i;
    {field_o, frame_o, line_o} <= sync_i;
  end
endmodule

// *** verif/video_input_pin_mapper_bench.sv ***
module video_input_pin_mapper_bench import pin_mapper_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [35:0] PAT = 36'h96a5c3e17;

  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic        wait_req;
  logic [35:0] word = 36'h0;
  logic [2:0]  sync = 3'h0;
  logic [35:0] pins;
  logic [2:0]  a_sync_in;
  logic [11:0] a_luma, a_blue, a_red;
  logic [9:0]  b_luma, b_chroma;
  logic [2:0]  a_sync, b_sync;
  logic        cap, main_sel;
  int          failures = 0;
  int          tests_run = 0;

  always #5 clk_i = ~clk_i;

  video_source_model src (.clk_i(clk_i), .word_i(word), .sync_i(sync), .pins_o(pins),
    .line_o(a_sync_in[0]), .frame_o(a_sync_in[1]), .field_o(a_sync_in[2]));

  video_input_pin_mapper DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .video_pins_i(pins), .port_a_line_active_i(a_sync_in[0]),
    .port_a_frame_active_i(a_sync_in[1]), .port_a_field_flag_i(a_sync_in[2]), .port_a_luma_o(a_luma),
    .port_a_blue_o(a_blue), .port_a_red_o(a_red), .port_b_luma_o(b_luma), .port_b_chroma_o(b_chroma),
    .port_a_line_active_o(a_sync[0]), .port_a_frame_active_o(a_sync[1]), .port_a_field_flag_o(a_sync[2]),
    .port_b_line_active_o(b_sync[0]), .port_b_frame_active_o(b_sync[1]), .port_b_field_flag_o(b_sync[2]),
    .capture_active_o(cap), .main_path_select_o(main_sel));

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_bus(input string what, input logic [31:0] want, input logic [31:0] got);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic check_comp(input string what, input logic [11:0] want, input logic [11:0] got);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask

  // One Avalon transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    be <= e;
    rd <= ~w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 40) begin
        failures++;
        print_verdict();
      end
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [11:0] rev12(input logic [11:0] x);
    logic [11:0] y;
    for (int i = 0; i < 12; i++) begin
      y[i] = x[11 - i];
    end
    return y;
  endfunction

  // Programs a configuration, checks status, then sends one word and checks every output.
  task automatic map_check(input logic [31:0] c, input logic [2:0] st, input logic [35:0] p,
                           input logic [11:0] l, b, r, bl, bc, input logic [2:0] bs);
    logic [31:0] q;
    bus(1'b1, CTRL_ADDR, c, 4'hf, q);
    repeat (2) @(posedge clk_i);
    bus(1'b0, STATUS_ADDR, 32'h0, 4'hf, q);
    check_bus("status", {13'h0, st, 6'h0, c[9:0]}, {13'h0, q[18:16], 6'h0, q[9:0]});
    word <= p;
    sync <= p[5:3];
    repeat (6) @(posedge clk_i);
    check_comp("a_luma", l, a_luma);
    check_comp("a_blue", b, a_blue);
    check_comp("a_red", r, a_red);
    check_comp("b_luma", bl, {2'h0, b_luma});
    check_comp("b_chroma", bc, {2'h0, b_chroma});
    check_bus("syncs", {26'h0, p[5:3], bs}, {26'h0, a_sync, b_sync});
    check_bus("ctrl_out", {30'h0, c[10:9]}, {30'h0, cap, main_sel});
  endtask

  task automatic s_reset();
    logic [31:0] q;
    check_bus("ctrl_out", 32'h1, {30'h0, cap, main_sel});
    bus(1'b0, CTRL_ADDR, 32'h0, 4'hf, q);
    check_bus("ctrl", {21'h0, CTRL_RESET}, q);
    bus(1'b0, 4'h8, 32'h0, 4'hf, q);
    check_bus("unmapped", 32'h0, q);
    bus(1'b1, 4'h8, 32'h0, 4'hf, q);
    bus(1'b1, STATUS_ADDR, 32'h0, 4'hf, q);
    bus(1'b1, CTRL_ADDR, 32'hffffffff, 4'h1, q);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'hf, q);
    check_bus("ctrl_lane0", {21'h0, CTRL_RESET[10:8], 8'hff}, q);
    bus(1'b1, CTRL_ADDR, 32'h0, 4'h2, q);
    bus(1'b0, CTRL_ADDR, 32'h0, 4'hf, q);
    check_bus("ctrl_lane1", 32'h000000ff, q);
  endtask

  task automatic s_narrow();
    map_check(32'h251, '0, PAT, PAT[35:26], '0, '0, PAT[25:16], '0, '0);
    map_check(32'h251, '0, PAT ^ 36'h00000ffff, PAT[35:26], '0, '0, PAT[25:16], '0, '0);
    map_check(32'h2d1, '0, PAT, PAT[35:28], '0, '0, PAT[25:18], '0, '0);
    map_check(32'h219, '0, PAT, PAT[35:26], PAT[25:16], '0, '0, '0, '0);
    map_check(32'h209, '0, PAT, PAT[35:28], PAT[25:18], '0, '0, '0, '0);
    map_check(32'h309, '0, PAT, PAT[27:20], PAT[19:12], PAT[35:28], '0, '0, '0);
    map_check(32'h109, 3'h2, PAT, PAT[27:20], PAT[19:12], PAT[35:28], '0, '0, '0);
    map_check(32'h257, '0, PAT, {PAT[27:20], PAT[15:14]}, '0, '0, {PAT[35:28], PAT[19:18]}, '0, '0);
    map_check(32'h255, '0, PAT, rev12({2'h0, PAT[33], PAT[32], PAT[27:20]}) >> 2, '0, '0,
              rev12({2'h0, PAT[29], PAT[28], PAT[19:12]}) >> 2, '0, '0);
    map_check(32'h2d5, '0, PAT, rev12({PAT[27:20], 4'h0}), '0, '0, rev12({PAT[19:12], 4'h0}), '0, '0);
    map_check(32'h2d7, '0, PAT, PAT[27:20], '0, '0, PAT[35:28], '0, '0);
    map_check(32'h30f, '0, PAT, PAT[27:20], PAT[19:12], PAT[35:28], '0, '0, '0);
    map_check(32'h30d, '0, PAT, rev12({PAT[27:20], 4'h0}), rev12({PAT[35:28], 4'h0}),
              rev12({PAT[19:12], 4'h0}), '0, '0, '0);
    map_check(32'h253, 3'h4, PAT, '0, '0, '0, '0, '0, '0);
  endtask

  task automatic s_full();
    map_check(32'h250, '0, PAT, PAT[35:26], '0, '0, PAT[15:6], '0, '0);
    map_check(32'h278, '0, PAT, PAT[35:26], PAT[25:16], '0, PAT[15:8], PAT[7:0], '0);
    map_check(32'h078, '0, PAT, PAT[35:26], PAT[25:16], '0, PAT[15:8], PAT[7:0], '0);
    map_check(32'h308, '0, PAT, PAT[35:26], PAT[25:16], PAT[15:6], '0, '0, '0);
    map_check(32'h300, '0, PAT, PAT[35:26], PAT[25:16], PAT[15:6], '0, '0, '0);
    map_check(32'h252, '0, PAT, PAT[35:28], '0, '0, PAT[19:12], '0, {PAT[0], PAT[2], PAT[1]});
    map_check(32'h27a, '0, PAT, PAT[35:28], PAT[27:20], '0, PAT[19:12], PAT[11:4], {PAT[0], PAT[2], PAT[1]});
    map_check(32'h27a, '0, PAT ^ 36'h8, PAT[35:28], PAT[27:20], '0, PAT[19:12], PAT[11:4], 3'h7);
    map_check(32'h304, '0, PAT, rev12(PAT[23:12]), rev12(PAT[35:24]), rev12(PAT[11:0]), '0, '0, '0);
    map_check(32'h306, '0, PAT, PAT[23:12], PAT[11:0], PAT[35:24], '0, '0, '0);
  endtask

  // A new map written while capture runs must stay pending and leave the path untouched.
  task automatic s_capture();
    logic [31:0] q;
    map_check(32'h706, '0, PAT, PAT[23:12], PAT[11:0], PAT[35:24], '0, '0, '0);
    bus(1'b1, CTRL_ADDR, 32'h704, 4'hf, q);
    repeat (2) @(posedge clk_i);
    bus(1'b0, STATUS_ADDR, 32'h0, 4'hf, q);
    check_bus("frozen", {15'h0, 1'b1, 6'h0, 10'h306}, {15'h0, q[16], 6'h0, q[9:0]});
    word <= ~PAT;
    repeat (6) @(posedge clk_i);
    check_comp("frozen_blue", ~PAT[11:0], a_blue);
    map_check(32'h304, '0, PAT, rev12(PAT[23:12]), rev12(PAT[35:24]), rev12(PAT[11:0]), '0, '0, '0);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    s_reset();
    s_narrow();
    s_full();
    s_capture();
    print_verdict();
  end
endmodule
